//--- src/cfg_ctrl_defines.vh
/*
 Constants for the configuration controller: register offsets, field
 positions, reset values, state codes and timing counts.
 Assumes inclusion by bare name from files under src/.
*/
// Notes on behaviour
// - Boundary-scan load overrides, aborts passive-serial load
// - Error without auto restart halts until request
// - Halted on error: status line held low
// - Request pulse low-high restarts fresh configuration
// - Auto restart: status pulses low then releases
// - Auto restart needs no request pulse
// - User pins high-impedance while configuring
// - Option off: release tri-states before clear
// - Option on: release clear before tri-states
// - Global clear off: pin is plain user pin
// - Global clear on: low pin clears registers
// - Scheme select sampled only before configuration done
`ifndef CFG_CTRL_DEFINES_VH
`define CFG_CTRL_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses)
`define REG_OPTIONS 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_CLEAR 12'h00C
`define REG_IRQ_ENABLE 12'h010
`define REG_CONTROL 12'h014

// ==========================================================
// Option fields
`define OPT_AUTO_RESTART 0
`define OPT_CLEARS_FIRST 1
`define OPT_GLOBAL_CLEAR 2
`define OPT_WIDTH 3
`define OPT_RESET 3'h0

// Control fields
`define CTL_START 0
`define CTL_IMAGE_ERR 1
`define CTL_IMAGE_DONE 2

// Interrupt event bits
`define EV_DONE 0
`define EV_ERROR 1
`define EV_JTAG_ABORT 2
`define EV_WIDTH 3

// ==========================================================
// Scheme select codes
`define SCHEME_PASSIVE_SERIAL 2'h1

// ==========================================================
// States, one-hot
`define ST_IDLE 7'h01
`define ST_LOAD 7'h02
`define ST_HALT 7'h04
`define ST_PULSE 7'h08
`define ST_INIT1 7'h10
`define ST_INIT2 7'h20
`define ST_USER 7'h40

// ==========================================================
// Timing: status low pulse and init step, in ns, at 10 ns clock
`define CLK_PERIOD_NS 10
`define PULSE_LOW_NS 40
`define INIT_STEP_NS 20
`define PULSE_CYCLES (`PULSE_LOW_NS / `CLK_PERIOD_NS)
`define STEP_CYCLES (`INIT_STEP_NS / `CLK_PERIOD_NS)
`define CNT_WIDTH 4

`define ZERO32 32'h0000_0000

`endif

//--- src/cfg_apb_regs.v
/*
 APB slave holding option, control and interrupt registers.
 Assumes a single clock and the synchronised active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfg_ctrl_defines.vh"

module cfg_apb_regs (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   input wire [31:0] i_state_word,
   input wire [`EV_WIDTH-1:0] i_events,
   output reg [`OPT_WIDTH-1:0] o_opts_r,
   output reg o_start_r,
   output reg o_img_err_r,
   output reg o_img_done_r,
   output wire o_irq
);
   reg [`EV_WIDTH-1:0] irq_stat_r; // Sticky event bits
   reg [`EV_WIDTH-1:0] irq_en_r; // Event enables
   reg [31:0] rdata_r; // Read data
   wire wr_en; // Write access phase
   wire known; // Mapped address

   // ==========================================================
   // Address decode
   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `REG_OPTIONS) || (a == `REG_STATUS) ||
            (a == `REG_IRQ_STATUS) || (a == `REG_IRQ_CLEAR) ||
            (a == `REG_IRQ_ENABLE) || (a == `REG_CONTROL);
      end
   endfunction

   assign known = is_mapped(i_paddr);
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign o_pready = 1'b1; // Zero wait states
   assign o_pslverr = i_psel & i_penable & ~known;
   assign o_irq = |(irq_stat_r & irq_en_r);

   // ==========================================================
   // Writes; control strobes are one-cycle pulses
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_opts_r <= `OPT_RESET;
         irq_en_r <= {`EV_WIDTH{1'b0}};
         irq_stat_r <= {`EV_WIDTH{1'b0}};
         o_start_r <= 1'b0;
         o_img_err_r <= 1'b0;
         o_img_done_r <= 1'b0;
      end else begin
         o_start_r <= 1'b0;
         o_img_err_r <= 1'b0;
         o_img_done_r <= 1'b0;
         if (wr_en && i_paddr == `REG_OPTIONS) begin
            o_opts_r <= i_pwdata[`OPT_WIDTH-1:0];
         end
         if (wr_en && i_paddr == `REG_IRQ_ENABLE) begin
            irq_en_r <= i_pwdata[`EV_WIDTH-1:0];
         end
         if (wr_en && i_paddr == `REG_CONTROL) begin
            o_start_r <= i_pwdata[`CTL_START];
            o_img_err_r <= i_pwdata[`CTL_IMAGE_ERR];
            o_img_done_r <= i_pwdata[`CTL_IMAGE_DONE];
         end
         // Set wins over clear
         if (wr_en && i_paddr == `REG_IRQ_CLEAR) begin
            irq_stat_r <= (irq_stat_r & ~i_pwdata[`EV_WIDTH-1:0]) | i_events;
         end else begin
            irq_stat_r <= irq_stat_r | i_events;
         end
      end
   end

   // ==========================================================
   // Read mux, registered in setup phase
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= `ZERO32;
      end else if (i_psel && !i_penable) begin
         case (i_paddr)
            `REG_OPTIONS: rdata_r <= {{(32-`OPT_WIDTH){1'b0}}, o_opts_r};
            `REG_STATUS: rdata_r <= i_state_word;
            `REG_IRQ_STATUS: rdata_r <= {{(32-`EV_WIDTH){1'b0}}, irq_stat_r};
            `REG_IRQ_ENABLE: rdata_r <= {{(32-`EV_WIDTH){1'b0}}, irq_en_r};
            default: rdata_r <= `ZERO32; // Clear, control, unmapped
         endcase
      end
   end
   assign o_prdata = rdata_r;
endmodule // cfg_apb_regs
`default_nettype wire

//--- src/cfg_ctrl.v
/*
 Configuration controller: passive-serial load with boundary-scan
 override, error halt or automatic restart, start-up release order and
 global clear. Registers over APB.
 Assumes synchronous pins and one 100 MHz clock.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_ctrl_defines.vh"

module cfg_ctrl (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   input wire [1:0] i_scheme_select,
   input wire i_config_request_n,
   input wire i_jtag_config,
   input wire i_config_status_n,
   output wire o_config_status_n_out,
   output wire o_config_status_n_oe_n,
   input wire i_global_clear_n,
   output wire o_global_clear_n_is_user,
   output reg o_user_io_oe_n_r,
   output reg o_user_clear_r,
   output reg o_user_mode_r,
   output wire o_irq
);
   reg [1:0] rst_sync_r; // Reset release chain
   wire rst_n; // Synchronised reset
   reg [6:0] state_r; // One-hot state
   reg [6:0] state_nxt;
   reg [`CNT_WIDTH-1:0] cnt_r; // Pulse / init counter
   reg [`CNT_WIDTH-1:0] cnt_nxt;
   reg req_prev_r; // Request line last cycle
   reg [1:0] scheme_r; // Captured scheme
   reg status_low_r; // Drive status line low
   reg [`OPT_WIDTH-1:0] opts_live_r; // Options latched from image
   reg [`EV_WIDTH-1:0] ev_r; // Event pulses
   wire [`OPT_WIDTH-1:0] opts_r;
   wire start_pulse, img_err, img_done;
   wire req_rise;
   wire gclr_act;

   // Counter loads kept at full width, trimmed on purpose where used
   localparam [31:0] PULSE_LOAD = `PULSE_CYCLES - 1;
   localparam [31:0] STEP_LOAD = `STEP_CYCLES - 1;

   // ==========================================================
   // Reset release
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ==========================================================
   // Register file
   cfg_apb_regs u_regs (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .i_state_word({16'h0000, 5'h00, ~i_config_status_n, scheme_r,
                     o_user_mode_r, state_r}),
      .i_events(ev_r),
      .o_opts_r(opts_r),
      .o_start_r(start_pulse),
      .o_img_err_r(img_err),
      .o_img_done_r(img_done),
      .o_irq(o_irq)
   );

   // Low-to-high on the request line
   assign req_rise = i_config_request_n & ~req_prev_r;

   // ==========================================================
   // Next-state logic
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         `ST_IDLE: begin
            // Begin when software starts and status line is high
            if (start_pulse && i_config_status_n) begin
               state_nxt = `ST_LOAD;
            end
         end
         `ST_LOAD: begin
            if (i_jtag_config) begin
               state_nxt = `ST_IDLE;
            end else if (img_err && opts_r[`OPT_AUTO_RESTART]) begin
               state_nxt = `ST_PULSE;
               cnt_nxt = PULSE_LOAD[`CNT_WIDTH-1:0];
            end else if (img_err) begin
               state_nxt = `ST_HALT;
            end else if (img_done) begin
               state_nxt = `ST_INIT1;
               cnt_nxt = STEP_LOAD[`CNT_WIDTH-1:0];
            end
         end
         `ST_HALT: begin
            if (req_rise) begin
               state_nxt = `ST_LOAD;
            end
         end
         `ST_PULSE: begin
            if (cnt_r == {`CNT_WIDTH{1'b0}}) begin
               state_nxt = `ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         `ST_INIT1: begin
            if (cnt_r == {`CNT_WIDTH{1'b0}}) begin
               state_nxt = `ST_INIT2;
               cnt_nxt = STEP_LOAD[`CNT_WIDTH-1:0];
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         `ST_INIT2: begin
            if (cnt_r == {`CNT_WIDTH{1'b0}}) begin
               state_nxt = `ST_USER;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         `ST_USER: begin
            if (req_rise) begin
               state_nxt = `ST_LOAD;
            end
         end
         default: begin
            state_nxt = `ST_IDLE;
         end
      endcase
      // Boundary-scan start aborts any passive load at once
      if (i_jtag_config && state_r == `ST_LOAD) begin
         state_nxt = `ST_IDLE;
      end
   end

   // ==========================================================
   // State, counters and events
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= `ST_IDLE;
         cnt_r <= {`CNT_WIDTH{1'b0}};
         req_prev_r <= 1'b1;
         scheme_r <= 2'b00;
         opts_live_r <= `OPT_RESET;
         ev_r <= {`EV_WIDTH{1'b0}};
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         req_prev_r <= i_config_request_n;
         // Scheme select counts only until user mode
         if (state_r != `ST_USER) begin
            scheme_r <= i_scheme_select;
         end
         // Global clear option takes effect from the loaded image; the other options act live
         if (img_done && state_r == `ST_LOAD) begin
            opts_live_r <= opts_r;
         end
         ev_r[`EV_DONE] <= (state_nxt == `ST_USER) && (state_r != `ST_USER);
         ev_r[`EV_ERROR] <= img_err && (state_r == `ST_LOAD);
         ev_r[`EV_JTAG_ABORT] <= i_jtag_config && (state_r == `ST_LOAD);
      end
   end

   // ==========================================================
   // Status line and start-up release order
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_low_r <= 1'b0;
         o_user_io_oe_n_r <= 1'b1;
         o_user_clear_r <= 1'b1;
         o_user_mode_r <= 1'b0;
      end else begin
         // Low while halted or pulsing
         status_low_r <= (state_nxt == `ST_HALT) || (state_nxt == `ST_PULSE);
         o_user_mode_r <= (state_nxt == `ST_USER);
         case (state_nxt)
            `ST_INIT2: begin
               // First release step chosen by ordering option
               o_user_io_oe_n_r <= opts_r[`OPT_CLEARS_FIRST];
               o_user_clear_r <= ~opts_r[`OPT_CLEARS_FIRST];
            end
            `ST_USER: begin
               o_user_io_oe_n_r <= 1'b0;
               o_user_clear_r <= gclr_act;
            end
            default: begin
               o_user_io_oe_n_r <= 1'b1;
               o_user_clear_r <= 1'b1;
            end
         endcase
      end
   end

   // Global clear acts only when enabled
   assign gclr_act = opts_live_r[`OPT_GLOBAL_CLEAR] & ~i_global_clear_n;
   assign o_global_clear_n_is_user = ~opts_live_r[`OPT_GLOBAL_CLEAR];
   // Open drain: drive 0, enable active low
   assign o_config_status_n_out = 1'b0;
   assign o_config_status_n_oe_n = ~status_low_r;
endmodule // cfg_ctrl
`default_nettype wire

//--- test/cfg_ctrl_properties.sv
/* Checker on the cfg_ctrl ports.
 Assumes one clock and the option word written over APB. */
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl_props (
   input wire i_ref_clk,
   input wire i_rstn,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire i_config_request_n,
   input wire i_global_clear_n,
   input wire o_config_status_n_oe_n,
   input wire o_global_clear_n_is_user,
   input wire o_user_io_oe_n_r,
   input wire o_user_clear_r,
   input wire o_user_mode_r
);
   // ====================
   // Option shadow
   reg [2:0] opt_r;
   // Mirrors writes so ordering checks know the mode
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         opt_r <= 3'h0;
      end else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000) begin
         opt_r <= i_pwdata[2:0];
      end
   end
   wire oe_n = o_config_status_n_oe_n;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // ====================
   // Assertions
   chk_ready_high: assert property (i_psel |-> o_pready)
      else $error("pready low in transfer");
   chk_unmapped_err: assert property (i_psel && i_penable && i_paddr > 12'h014 |-> o_pslverr)
      else $error("unmapped access not refused");
   chk_pins_tristated: assert property (!oe_n |-> o_user_io_oe_n_r && !o_user_mode_r)
      else $error("pins driven while configuring");
   chk_tristate_first: assert property ($fell(o_user_io_oe_n_r) && !opt_r[1]
      |-> o_user_clear_r)
      else $error("clear released too early");
   chk_clear_first: assert property ($fell(o_user_io_oe_n_r) && opt_r[1]
      |-> !$past(o_user_clear_r))
      else $error("clear released too late");
   chk_halt_hold: assert property ($fell(oe_n) && !opt_r[0] |-> !oe_n [*8])
      else $error("halt status not held");
   chk_auto_pulse: assert property ($fell(oe_n) && opt_r[0] |-> !oe_n [*4] ##1 oe_n)
      else $error("status pulse wrong");
   chk_restart_req: assert property ($rose(i_config_request_n) && !oe_n && !opt_r[0]
      |-> ##[1:3] oe_n)
      else $error("request did not leave halt");
   chk_gclr_user: assert property (o_user_mode_r && o_global_clear_n_is_user
      |-> !o_user_clear_r)
      else $error("clear pin acted while off");
   chk_gclr_clear: assert property (o_user_mode_r && !o_global_clear_n_is_user
      && !i_global_clear_n |-> ##[1:2] o_user_clear_r)
      else $error("clear pin ignored");
   cover property ($fell(oe_n) && opt_r[0]);
   cover property ($rose(o_user_mode_r));
   cover property (o_pslverr);
endmodule // cfg_ctrl_props
bind cfg_ctrl cfg_ctrl_props u_props (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_config_request_n(i_config_request_n),
   .i_global_clear_n(i_global_clear_n), .o_config_status_n_oe_n(o_config_status_n_oe_n),
   .o_global_clear_n_is_user(o_global_clear_n_is_user), .o_user_io_oe_n_r(o_user_io_oe_n_r),
   .o_user_clear_r(o_user_clear_r), .o_user_mode_r(o_user_mode_r));
`default_nettype wire

//--- test/cfg_source_model.sv
/* Configuration source on the status line.
 Assumes an active-low pin enable and a pull-up on the wire. */
`timescale 1ns/1ps
`default_nettype none
module cfg_source_model (
   input wire logic clk,
   input wire logic status_oe_n,
   input wire logic status_out,
   output logic status_line,
   output logic [7:0] restarts
);
   logic line_q;
   // Pull-up wins whenever the device lets go
   assign status_line = status_oe_n ? 1'h1 : status_out;
   initial restarts = 8'h00;
   initial line_q = 1'h1;
   // Source sits in reset while low, restarts on release
   always @(posedge clk) begin
      line_q <= status_line;
      if (status_line && !line_q) begin
         restarts <= restarts + 8'h01;
      end
   end
endmodule // cfg_source_model
`default_nettype wire

//--- test/config_error_restart_and_startup_tb_top.sv
/* Bench for cfg_ctrl: APB master, source model, checks.
 Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module config_error_restart_and_startup_tb_top;
   logic clk, rstn, psel, penable, pwrite, req_n, jtag, gclr_n, cf, err;
   logic pready, pslverr, st_out, st_oe_n, line, is_user, io_oe_n, uclr, umode, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] scheme;
   logic [7:0] restarts;
   int bad_count, total_checks, cyc;
   cfg_ctrl DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_scheme_select(scheme),
      .i_config_request_n(req_n), .i_jtag_config(jtag), .i_config_status_n(line),
      .o_config_status_n_out(st_out), .o_config_status_n_oe_n(st_oe_n),
      .i_global_clear_n(gclr_n), .o_global_clear_n_is_user(is_user),
      .o_user_io_oe_n_r(io_oe_n), .o_user_clear_r(uclr), .o_user_mode_r(umode), .o_irq(irq));
   cfg_source_model src (.clk(clk), .status_oe_n(st_oe_n), .status_out(st_out),
      .status_line(line), .restarts(restarts));
   // ====================
   // Helpers
   function automatic [31:0] stw(input low, input [2:0] n);
      stw = {21'h0, low, 2'h1, 1'h0, 7'h01 << n};
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until pready is seen high
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task pulse_req;
      req_n <= 1'h0;
      repeat (2) @(posedge clk);
      req_n <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
   task wait_user;
      for (int n = 0; n < 40 && umode !== 1'h1; n++) @(negedge clk);
      chk(umode, 1);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ====================
   // Clock and watchdog
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         close_out;
      end
   end
   // ====================
   // Main sequence
   initial begin
      {psel, penable, pwrite, req_n, jtag, gclr_n, rstn} = 7'h0A;
      {paddr, pwdata} = '0;
      scheme = 2'h1;
      void'($urandom(22));
      cf = 1'($urandom);
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      // Reset values and a refused address
      apb(0, 12'h000, 0);
      chk(rd, 0);
      apb(0, 12'h020, 0);
      chk(rd, 0);
      chk({31'h0, err}, 1);
      // Boundary-scan abort raises the interrupt
      apb(1, 12'h010, 32'h0000_0007);
      apb(1, 12'h014, 32'h0000_0001);
      jtag <= 1'h1;
      repeat (3) @(posedge clk);
      jtag <= 1'h0;
      apb(0, 12'h004, 0);
      chk(rd, stw(0, 0));
      apb(0, 12'h008, 0);
      chk(rd[2:0], 3'h4);
      apb(1, 12'h010, 32'h0000_0000);
      @(negedge clk);
      chk(irq, 0);
      apb(1, 12'h010, 32'h0000_0007);
      @(negedge clk);
      chk(irq, 1);
      apb(1, 12'h00C, 32'h0000_0007);
      @(negedge clk);
      chk(irq, 0);
      // Error halts until the request line toggles
      apb(1, 12'h000, {30'h0, cf, 1'h0});
      apb(1, 12'h014, 32'h0000_0001);
      apb(1, 12'h014, 32'h0000_0002);
      repeat (10) @(posedge clk);
      apb(0, 12'h004, 0);
      chk(rd, stw(1, 2));
      chk(line, 0);
      pulse_req;
      apb(0, 12'h004, 0);
      chk(rd, stw(0, 1));
      chk(io_oe_n, 1);
      apb(1, 12'h014, 32'h0000_0004);
      wait_user;
      chk({io_oe_n, uclr, is_user}, 3'h1);
      // Auto restart, then global clear in user mode
      apb(1, 12'h000, {29'h0, 1'h1, ~cf, 1'h1});
      pulse_req;
      apb(1, 12'h014, 32'h0000_0002);
      repeat (10) @(posedge clk);
      apb(0, 12'h004, 0);
      chk(rd, stw(0, 0));
      chk(restarts, 2);
      apb(1, 12'h014, 32'h0000_0001);
      apb(0, 12'h004, 0);
      chk(rd, stw(0, 1));
      apb(1, 12'h014, 32'h0000_0004);
      wait_user;
      @(posedge clk);
      // A strap of 2 or 3 in place of the captured 1 must be ignored now
      scheme <= 2'($urandom) | 2'h2;
      gclr_n <= 1'h0;
      repeat (3) @(posedge clk);
      chk({uclr, is_user}, 2'h2);
      apb(0, 12'h004, 0);
      chk(rd[9:8], 1);
      close_out;
   end
endmodule // config_error_restart_and_startup_tb_top
`default_nettype wire
